// ===== rtl/gcm_consts.svh
// Address, field and timing constants of the global command and misc control registers
`ifndef GCM_CONSTS_SVH
`define GCM_CONSTS_SVH
`define GCM_MISC_LO_ADDR 7'h34
`define GCM_MISC_HI_ADDR 7'h35
`define GCM_CMD_LO_ADDR 7'h3E
`define GCM_CMD_HI_ADDR 7'h3F
`define GCM_CMD_RESET_BIT 7
`define GCM_CMD_FLASH_BIT 3
`define GCM_CMD_DAC_BIT 2
`define GCM_CMD_FACTORY_BIT 1
`define GCM_CMD_NULL_BIT 0
`define GCM_CMD_READ_VALUE 8'h00
`define GCM_MISC_RESET 16'h0000
`define GCM_MISC_MASK 16'h0107
`define GCM_MISC_ST_BIT 8
`define GCM_MISC_DR_EN_BIT 2
`define GCM_MISC_DR_POL_BIT 1
`define GCM_MISC_DR_SEL_BIT 0
`define GCM_UNMAPPED_READ 8'h00
`define GCM_FLASH_TIME_MS 50
`define GCM_CLK_KHZ 250000
`endif

// ===== rtl/gcm_pkg.sv
// Types shared by the global command and misc control block
package gcm_pkg;
   typedef logic [6:0] gcm_addr_t;
   typedef logic [7:0] gcm_byte_t;
   // Flash store sequencer, Gray along idle -> busy -> again
   typedef enum logic [1:0] {
      GCM_FL_IDLE = 2'b00,
      GCM_FL_BUSY = 2'b01,
      GCM_FL_AGAIN = 2'b11
   } gcm_flash_state_t;
endpackage

// ===== rtl/gcm_hold_timer.sv
// Down-counter that flags the end of a fixed hold time after each start
`timescale 1ns/1ps
module gcm_hold_timer #(
   parameter int unsigned COUNT = 12500000,
   parameter int unsigned W = $clog2(COUNT + 1)
) (
   input wire logic clk,
   input wire logic rst_sync_n,
   input wire logic start,
   output logic done
);
   logic [W-1:0] count_q;
   logic [W-1:0] count_d;
   logic done_q;
   logic done_d;

   // A new start reloads the count, so a restart stretches the hold
   always_comb begin
      count_d = count_q;
      done_d = 1'b0;
      if (start) begin
         count_d = W'(COUNT);
      end else if (count_q != '0) begin
         count_d = count_q - W'(1);
         done_d = (count_q == W'(1));
      end
   end

   // Count and done registers
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count_q <= '0;
         done_q <= 1'b0;
      end else begin
         count_q <= count_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;
endmodule

// ===== rtl/gcm_ctrl.sv
// Global command register and miscellaneous control register with data-ready pin mux
`timescale 1ns/1ps
`include "gcm_consts.svh"
module gcm_ctrl #(
   parameter int unsigned FLASH_CYCLES = `GCM_FLASH_TIME_MS * `GCM_CLK_KHZ
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire gcm_pkg::gcm_addr_t wr_addr,
   input wire gcm_pkg::gcm_byte_t wr_data,
   input wire logic rd_en,
   input wire gcm_pkg::gcm_addr_t rd_addr,
   output gcm_pkg::gcm_byte_t rd_data,
   input wire logic [11:0] aux_dac_data,
   input wire logic [2:0] nv_dr_cfg,
   input wire logic conv_done,
   input wire logic conv_midway,
   input wire logic [1:0] alarm_oe,
   input wire logic [1:0] alarm_out,
   input wire logic [1:0] gpio_oe,
   input wire logic [1:0] gpio_out,
   output logic soft_reset,
   output logic flash_store,
   output logic flash_busy,
   output logic dac_load,
   output logic [11:0] dac_value,
   output logic offset_restore,
   output logic filter_clear,
   output logic null_zero,
   output logic self_test_on,
   output logic [2:0] misc_dr_cfg,
   output logic general_line_zero_dout,
   output logic general_line_zero_oe,
   output logic general_line_one_dout,
   output logic general_line_one_oe
);
   import gcm_pkg::*;

   logic rst_meta_q;
   logic rst_sync_n;
   logic loaded_q;
   logic loaded_d;
   logic [15:0] misc_q;
   logic [15:0] misc_d;
   gcm_byte_t rd_data_q;
   gcm_byte_t rd_data_d;
   logic soft_q;
   logic soft_d;
   logic dac_load_q;
   logic dac_load_d;
   logic [11:0] dac_q;
   logic [11:0] dac_d;
   logic restore_q;
   logic restore_d;
   logic null_q;
   logic null_d;
   logic cmd_hit;
   logic store_req;
   gcm_flash_state_t fl_q;
   gcm_flash_state_t fl_d;
   logic fl_start_q;
   logic fl_start_d;
   logic fl_busy_q;
   logic fl_busy_d;
   logic fl_done;
   logic dr_active_q;
   logic dr_active_d;
   logic dr_pin;
   logic [1:0] dr_claim;
   logic [1:0] line_oe_q;
   logic [1:0] line_oe_d;
   logic [1:0] line_out_q;
   logic [1:0] line_out_d;

   // Misc control answers at both of its byte addresses
   function automatic logic is_misc(input gcm_addr_t a);
      is_misc = (a == `GCM_MISC_LO_ADDR) || (a == `GCM_MISC_HI_ADDR);
   endfunction

   // Read mux; command bytes and anything unmapped read zero
   function automatic gcm_byte_t read_byte(input gcm_addr_t a, input logic [15:0] m);
      if (is_misc(a)) begin
         read_byte = a[0] ? m[15:8] : m[7:0];
      end else if (a == `GCM_CMD_LO_ADDR || a == `GCM_CMD_HI_ADDR) begin
         read_byte = `GCM_CMD_READ_VALUE;
      end else begin
         read_byte = `GCM_UNMAPPED_READ;
      end
   endfunction

   // Reset release through two flops; the asserting edge stays asynchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   assign cmd_hit = wr_en && (wr_addr == `GCM_CMD_LO_ADDR);

   // Register file: misc control, command pulses, DAC latch, read data
   always_comb begin
      misc_d = misc_q;
      loaded_d = 1'b1;
      soft_d = 1'b0;
      dac_load_d = 1'b0;
      dac_d = dac_q;
      restore_d = 1'b0;
      null_d = 1'b0;
      store_req = 1'b0;
      rd_data_d = rd_data_q;
      if (!loaded_q) begin
         // Data-ready fields come back from nonvolatile storage, self-test off
         misc_d = {13'h0000, nv_dr_cfg} & `GCM_MISC_MASK;
      end else if (wr_en && is_misc(wr_addr)) begin
         if (wr_addr[0]) begin
            misc_d = {wr_data, misc_q[7:0]} & `GCM_MISC_MASK;
         end else begin
            misc_d = {misc_q[15:8], wr_data} & `GCM_MISC_MASK;
         end
      end
      if (soft_q) begin
         // Software reset redoes the reset load of misc control only: self-test off, data-ready fields reloaded
         loaded_d = 1'b0;
         misc_d[`GCM_MISC_ST_BIT] = 1'b0;
      end
      if (cmd_hit) begin
         soft_d = wr_data[`GCM_CMD_RESET_BIT];
         restore_d = wr_data[`GCM_CMD_FACTORY_BIT];
         null_d = wr_data[`GCM_CMD_NULL_BIT];
         store_req = wr_data[`GCM_CMD_FLASH_BIT] | wr_data[`GCM_CMD_FACTORY_BIT]
            | wr_data[`GCM_CMD_NULL_BIT];
         if (wr_data[`GCM_CMD_DAC_BIT]) begin
            // Both data bytes move in one step, so the DAC never sees half a word
            dac_load_d = 1'b1;
            dac_d = aux_dac_data;
         end
      end
      if (rd_en) begin
         rd_data_d = read_byte(rd_addr, misc_q);
      end
   end

   // Register file state
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         loaded_q <= 1'b0;
         misc_q <= `GCM_MISC_RESET;
         soft_q <= 1'b0;
         dac_load_q <= 1'b0;
         dac_q <= 12'h000;
         restore_q <= 1'b0;
         null_q <= 1'b0;
         rd_data_q <= 8'h00;
      end else begin
         loaded_q <= loaded_d;
         misc_q <= misc_d;
         soft_q <= soft_d;
         dac_load_q <= dac_load_d;
         dac_q <= dac_d;
         restore_q <= restore_d;
         null_q <= null_d;
         rd_data_q <= rd_data_d;
      end
   end

   // Flash store sequencer; a request during a store queues one more store
   always_comb begin
      fl_d = fl_q;
      fl_start_d = 1'b0;
      case (fl_q)
         GCM_FL_IDLE: begin
            if (store_req) begin
               fl_start_d = 1'b1;
               fl_d = GCM_FL_BUSY;
            end
         end
         GCM_FL_BUSY: begin
            if (fl_done && store_req) begin
               fl_start_d = 1'b1;
            end else if (fl_done) begin
               fl_d = GCM_FL_IDLE;
            end else if (store_req) begin
               fl_d = GCM_FL_AGAIN;
            end
         end
         GCM_FL_AGAIN: begin
            // Store again so later register changes also reach flash
            if (fl_done) begin
               fl_start_d = 1'b1;
               fl_d = GCM_FL_BUSY;
            end
         end
         default: begin
            fl_d = GCM_FL_IDLE;
         end
      endcase
      fl_busy_d = (fl_d != GCM_FL_IDLE);
   end

   // Flash sequencer state
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fl_q <= GCM_FL_IDLE;
         fl_start_q <= 1'b0;
         fl_busy_q <= 1'b0;
      end else begin
         fl_q <= fl_d;
         fl_start_q <= fl_start_d;
         fl_busy_q <= fl_busy_d;
      end
   end

   // Hold time for the flash write
   gcm_hold_timer #(
      .COUNT(FLASH_CYCLES)
   ) u_flash_timer (
      .clk(clk),
      .rst_sync_n(rst_sync_n),
      .start(fl_start_q),
      .done(fl_done)
   );

   // Data-ready level; a completion in the clear cycle wins
   always_comb begin
      dr_active_d = dr_active_q;
      if (conv_done) begin
         dr_active_d = 1'b1;
      end else if (conv_midway) begin
         dr_active_d = 1'b0;
      end
   end

   assign dr_pin = misc_q[`GCM_MISC_DR_POL_BIT] ? dr_active_q : ~dr_active_q;

   // Per-line owner mux: data-ready, then alarm, then pin I/O control
   for (genvar i = 0; i < 2; i++) begin : g_line
      assign dr_claim[i] = misc_q[`GCM_MISC_DR_EN_BIT]
         && (misc_q[`GCM_MISC_DR_SEL_BIT] == 1'(i));
      assign line_oe_d[i] = dr_claim[i] | alarm_oe[i] | gpio_oe[i];
      assign line_out_d[i] = dr_claim[i] ? dr_pin
         : (alarm_oe[i] ? alarm_out[i] : gpio_out[i]);
   end

   // Pin and data-ready registers; the lines idle as inputs after reset
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dr_active_q <= 1'b0;
         line_oe_q <= 2'b00;
         line_out_q <= 2'b00;
      end else begin
         dr_active_q <= dr_active_d;
         line_oe_q <= line_oe_d;
         line_out_q <= line_out_d;
      end
   end

   // Every output straight from a flop
   assign rd_data = rd_data_q;
   assign soft_reset = soft_q;
   assign flash_store = fl_start_q;
   assign flash_busy = fl_busy_q;
   assign dac_load = dac_load_q;
   assign dac_value = dac_q;
   assign offset_restore = restore_q;
   assign filter_clear = restore_q;
   assign null_zero = null_q;
   assign self_test_on = misc_q[`GCM_MISC_ST_BIT];
   assign misc_dr_cfg = misc_q[2:0];
   assign general_line_zero_dout = line_out_q[0];
   assign general_line_zero_oe = line_oe_q[0];
   assign general_line_one_dout = line_out_q[1];
   assign general_line_one_oe = line_oe_q[1];

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_n);

   AST_CMD_ZERO_QUIET:
   assert property (cmd_hit && wr_data == 8'h00 |=>
      !soft_reset && !dac_load && !offset_restore && !null_zero)
      else $error("zero command write fired a command");
   AST_CMD_READS_ZERO:
   assert property (rd_en && (rd_addr == `GCM_CMD_LO_ADDR || rd_addr == `GCM_CMD_HI_ADDR)
      |=> rd_data == 8'h00)
      else $error("command register read not zero");
   AST_SOFT_RESET_PULSE:
   assert property (cmd_hit && wr_data[7] |=> soft_reset ##1 !soft_reset)
      else $error("software reset not a single pulse");
   AST_FLASH_START:
   assert property (cmd_hit && wr_data[3] && fl_q == GCM_FL_IDLE |=> flash_store ##1 flash_busy)
      else $error("flash store did not start");
   AST_DAC_LATCH:
   assert property (cmd_hit && wr_data[2] |=> dac_load && dac_value == $past(aux_dac_data))
      else $error("DAC latch missed");
   AST_DAC_STEADY:
   assert property ($changed(dac_value) |-> dac_load)
      else $error("DAC output moved without latch");
   AST_FACTORY_RESTORE:
   assert property (cmd_hit && wr_data[1] && fl_q == GCM_FL_IDLE
      |=> offset_restore && filter_clear && flash_store)
      else $error("factory restore incomplete");
   AST_NULL_STORE:
   assert property (cmd_hit && wr_data[0] && fl_q == GCM_FL_IDLE |=> null_zero && flash_store)
      else $error("null command incomplete");
   AST_DR_LINE_ONE:
   assert property (misc_q[2] && misc_q[0] |=> general_line_one_oe
      && general_line_one_dout == ($past(misc_q[1]) ~^ $past(dr_active_q)))
      else $error("data-ready not driven on line one");
   AST_DR_SET_WINS:
   assert property (conv_done |=> dr_active_q)
      else $error("data-ready not set on completion");
   AST_DR_CLEAR:
   assert property (conv_midway && !conv_done |=> !dr_active_q)
      else $error("data-ready not cleared midway");
   AST_ALARM_OVER_GPIO:
   assert property (alarm_oe[0] && !dr_claim[0]
      |=> general_line_zero_oe && general_line_zero_dout == $past(alarm_out[0]))
      else $error("alarm lost priority on line zero");
   AST_SELF_TEST_SET:
   assert property (wr_en && wr_addr == `GCM_MISC_HI_ADDR && wr_data[0] && loaded_q && !soft_q
      |=> self_test_on)
      else $error("self-test not enabled");
   AST_SOFT_CLEARS_ST:
   assert property (soft_reset |=> !self_test_on ##1 misc_dr_cfg == $past(nv_dr_cfg))
      else $error("software reset did not restore misc control");
   AST_MISC_UNUSED_ZERO:
   assert property (rd_en && rd_addr == `GCM_MISC_HI_ADDR |=> rd_data[7:1] == 7'h00)
      else $error("unused misc bits read non-zero");
endmodule

// ===== bench/gcm_host_model.sv
// Host model: byte writes and reads on the register port, plus DAC data staging
`timescale 1ns/1ps
module gcm_host_model (
   input wire logic clk,
   output logic wr_en,
   output gcm_pkg::gcm_addr_t wr_addr,
   output gcm_pkg::gcm_byte_t wr_data,
   output logic rd_en,
   output gcm_pkg::gcm_addr_t rd_addr,
   input wire gcm_pkg::gcm_byte_t rd_data,
   output logic [11:0] aux_dac_data
);
   import gcm_pkg::*;
   // Idle bus at time zero
   initial begin
      wr_en = 1'b0;
      wr_addr = 7'h00;
      wr_data = 8'h00;
      rd_en = 1'b0;
      rd_addr = 7'h00;
      aux_dac_data = 12'h000;
   end
   // One byte write; data is inverted once released so stale values never match
   task automatic write_byte(input gcm_addr_t a, input gcm_byte_t d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      wr_data <= ~d;
      // Both DAC bytes staged here before any latch command
      if (a == 7'h30) aux_dac_data <= {aux_dac_data[11:8], d};
      if (a == 7'h31) aux_dac_data <= {d[3:0], aux_dac_data[7:0]};
   endtask
   // One byte read; rd_data holds, so it is taken a cycle later
   task automatic read_byte(input gcm_addr_t a, output gcm_byte_t d);
      @(posedge clk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      #1 d = rd_data;
   endtask
endmodule

// ===== bench/tb.sv
// Self-checking testbench for the global command and misc control block
`timescale 1ns/1ps
module tb;
   import gcm_pkg::*;
   localparam int unsigned FLASH_N = 20;
   logic clk, rst_n, wr_en, rd_en, conv_done, conv_midway;
   gcm_addr_t wr_addr, rd_addr;
   gcm_byte_t wr_data, rd_data, rb;
   logic [11:0] aux_dac_data, dac_value;
   logic [2:0] nv_dr_cfg, misc_dr_cfg;
   logic [1:0] alarm_oe, alarm_out, gpio_oe, gpio_out;
   logic soft_reset, flash_store, flash_busy, dac_load, offset_restore, filter_clear;
   logic null_zero, self_test_on, l0_dout, l0_oe, l1_dout, l1_oe;
   logic [5:0] pv;
   logic [3:0] pin_now;
   logic [2:0] pc [6];
   int err_total = 0;
   int cmp_count = 0;
   gcm_host_model host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .aux_dac_data(aux_dac_data));
   gcm_ctrl #(.FLASH_CYCLES(FLASH_N)) dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .aux_dac_data(aux_dac_data), .nv_dr_cfg(nv_dr_cfg),
      .conv_done(conv_done), .conv_midway(conv_midway), .alarm_oe(alarm_oe),
      .alarm_out(alarm_out), .gpio_oe(gpio_oe), .gpio_out(gpio_out),
      .soft_reset(soft_reset), .flash_store(flash_store), .flash_busy(flash_busy),
      .dac_load(dac_load), .dac_value(dac_value), .offset_restore(offset_restore),
      .filter_clear(filter_clear), .null_zero(null_zero), .self_test_on(self_test_on),
      .misc_dr_cfg(misc_dr_cfg), .general_line_zero_dout(l0_dout),
      .general_line_zero_oe(l0_oe), .general_line_one_dout(l1_dout),
      .general_line_one_oe(l1_oe));
   // Pulse outputs counted mid-cycle, so a stuck pulse shows as a count above one
   assign pv = {soft_reset, flash_store, dac_load, offset_restore, filter_clear, null_zero};
   // Both lines as {one_oe, one_dout, zero_oe, zero_dout}
   assign pin_now = {l1_oe, l1_dout, l0_oe, l0_dout};
   always @(negedge clk) begin
      for (int i = 0; i < 6; i++) begin
         if (pv[i] === 1'b1) pc[i] <= pc[i] + 3'h1;
      end
   end
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      // Everything idles while reset is held
      check(16'({rd_data, misc_dr_cfg}), 16'h0000);
      check(16'({self_test_on, soft_reset, flash_busy, l1_oe, l0_oe}), 16'h0000);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   // Command write; exp lists which pulses must appear exactly once
   task automatic run_cmd(input gcm_addr_t a, input gcm_byte_t d, input logic [5:0] exp);
      int n;
      for (int i = 0; i < 6; i++) pc[i] = 3'h0;
      host.write_byte(a, d);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 6; i++) check(16'(pc[i]), 16'(exp[i]));
      check(16'(flash_busy), 16'(exp[4]));
      n = 0;
      while (flash_busy !== 1'b0 && n < FLASH_N + 8) begin
         @(posedge clk);
         n++;
      end
      if (flash_busy !== 1'b0) begin
         err_total++;
         give_verdict();
      end
      if (exp[4]) check(16'(n >= FLASH_N - 6), 16'h0001);
   endtask
   // Second store request while busy queues one more store behind it
   task automatic flash_queue;
      int n;
      for (int i = 0; i < 6; i++) pc[i] = 3'h0;
      host.write_byte(7'h3E, 8'h08);
      repeat (3) @(posedge clk);
      host.write_byte(7'h3E, 8'h08);
      n = 0;
      while (flash_busy !== 1'b0 && n < 2 * FLASH_N + 16) begin
         @(posedge clk);
         n++;
      end
      if (flash_busy !== 1'b0) begin
         err_total++;
         give_verdict();
      end
      check(16'(pc[4]), 16'h0002);
      check(16'(n >= FLASH_N + 10), 16'h0001);
   endtask
   // Expected pins {one_oe, one_dout, zero_oe, zero_dout} for a cfg and ready level
   function automatic logic [3:0] pins(input logic [2:0] c, input logic lv);
      logic [1:0] oe, dt;
      for (int l = 0; l < 2; l++) begin
         oe[l] = 1'b1;
         if (c[2] && c[0] == l) dt[l] = c[1] ? lv : ~lv;
         else if (alarm_oe[l]) dt[l] = alarm_out[l];
         else dt[l] = gpio_out[l];
      end
      return {oe[1], dt[1], oe[0], dt[0]};
   endfunction
   // Inputs move only on rising edges; pins are read 1 ns after an edge
   task automatic dr_case(input logic [2:0] c);
      host.write_byte(7'h34, {5'h00, c});
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check(16'(pin_now), 16'(pins(c, 1'b1)));
      check(16'(misc_dr_cfg), 16'(c));
      @(posedge clk);
      conv_midway <= 1'b1;
      @(posedge clk);
      conv_midway <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check(16'(pin_now), 16'(pins(c, 1'b0)));
      @(posedge clk);
   endtask
   // Completion and mid-cycle drop together: completion wins
   task automatic dr_both;
      host.write_byte(7'h34, 8'h07);
      conv_midway <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      conv_midway <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check(16'({l1_oe, l1_dout}), 16'h0003);
      @(posedge clk);
   endtask
   initial begin
      rst_n = 1'b0;
      conv_done = 1'b0;
      conv_midway = 1'b0;
      nv_dr_cfg = 3'h5;
      alarm_oe = 2'h1;
      alarm_out = 2'h1;
      gpio_oe = 2'h3;
      gpio_out = 2'h2;
      for (int i = 0; i < 6; i++) pc[i] = 3'h0;
      do_reset();
      host.read_byte(7'h34, rb);
      check(16'(rb), 16'h0005);
      host.read_byte(7'h35, rb);
      check(16'(rb), 16'h0000);
      host.read_byte(7'h3E, rb);
      check(16'(rb), 16'h0000);
      host.read_byte(7'h10, rb);
      check(16'(rb), 16'h0000);
      // Each command but the DAC latch alone, a shared store, unused bits, high byte and zero
      run_cmd(7'h3E, 8'h80, 6'h20);
      run_cmd(7'h3E, 8'h08, 6'h10);
      run_cmd(7'h3E, 8'h02, 6'h16);
      run_cmd(7'h3E, 8'h01, 6'h11);
      run_cmd(7'h3E, 8'h0B, 6'h17);
      run_cmd(7'h3E, 8'h70, 6'h00);
      run_cmd(7'h3F, 8'hFF, 6'h00);
      run_cmd(7'h3E, 8'h00, 6'h00);
      flash_queue();
      host.read_byte(7'h3E, rb);
      check(16'(rb), 16'h0000);
      // DAC bytes alone must not move the output
      host.write_byte(7'h30, 8'hBC);
      host.write_byte(7'h31, 8'h0A);
      check(16'(dac_value), 16'h0000);
      run_cmd(7'h3E, 8'h04, 6'h08);
      check(16'(dac_value), 16'h0ABC);
      // Self-test bit and unused misc bits
      host.write_byte(7'h35, 8'hFF);
      host.write_byte(7'h34, 8'hFA);
      repeat (2) @(posedge clk);
      check(16'(self_test_on), 16'h0001);
      host.read_byte(7'h35, rb);
      check(16'(rb), 16'h0001);
      host.read_byte(7'h34, rb);
      check(16'(rb), 16'h0002);
      run_cmd(7'h3E, 8'h80, 6'h20);
      check(16'(self_test_on), 16'h0000);
      check(16'(misc_dr_cfg), 16'h0005);
      host.write_byte(7'h35, 8'h01);
      host.write_byte(7'h35, 8'h00);
      repeat (2) @(posedge clk);
      check(16'(self_test_on), 16'h0000);
      // Every cfg, then with alarm released to pin I/O control
      for (int c = 0; c < 8; c++) dr_case(3'(c));
      alarm_oe <= 2'h0;
      dr_case(3'h0);
      dr_case(3'h6);
      dr_both();
      // Mid-run reset reloads the stored cfg and drops self-test
      host.write_byte(7'h35, 8'h01);
      nv_dr_cfg <= 3'h3;
      do_reset();
      check(16'(misc_dr_cfg), 16'h0003);
      check(16'(self_test_on), 16'h0000);
      give_verdict();
   end
endmodule
